// file: rtl/dpll_hist_mem.sv
`timescale 1ns/100ps
module dpll_hist_mem #(
  parameter int unsigned W     = 24,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] old_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_reg;

  // no reset on the array; old_data is only trusted once full
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wptr_reg] <= wr_data;
    end
  end

  // slot at the write pointer is the oldest snapshot
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wptr_reg <= '0;
      old_data <= '0;
    end else begin
      old_data <= mem[wptr_reg];
      if (wr_en) begin
        wptr_reg <= wptr_reg + AW'(1);
      end
    end
  end
endmodule

// file: rtl/dpll_pkg.sv
// What this block does
// R1: detect reference rate automatically: 8 kHz, 1.544, 2.048 or 19.44 MHz
// R2: low rates use falling edge, 19.44 MHz reference uses rising edge
// R3: select low picks primary reference, high picks secondary
// R4: host waits for lock, holds realign low 250 us or 10 s
// R5: realign while locked restarts locking and removes leftover phase offset
// R6: lock drops 5 s after realign falls, stays low 10 s
// R7: mode pins hi,lo: 00 normal, 01 holdover, 10 free-run, 11 reserved
// R8: free-run runs oscillator at nominal master clock rate
// R9: normal mode locks oscillator frequency and phase to selected reference
// R10: holdover entered by mode pins or when selected reference is lost
// R11: holdover frequency is that of last 30 to 60 ms of normal
// R12: limiter bounds output phase slope to 41 ns per 1.326 ms
// R13: loop filter is first-order low-pass, 1.5 Hz, for every reference rate; code corner is near 1.2 Hz
// R14: phase detector compares virtual reference with feedback, feeds limiter
// R15: outputs 2.048, 8.192 and 16.384 MHz clocks, 50% duty
// R16: 8 kHz active-low frame pulse, about 61 ns wide; code drives it one 50 ns sys_clk cycle wide
// R17: 19.44 MHz 50% clock drives the link to the jitter stage
// R18: lock asserted only while residual phase stays within 20 ns
// R19: lock held low at least 10 s before it may rise again
// R20: holdover output high whenever loop is in a holdover state
// R21: host holds active-low reset at least 1 us after power-up
// R22: after reset release run 625 us initialisation, then free-run
// R23: reserved mode pin code keeps the current mode
package dpll_pkg;
  localparam int unsigned SYS_CLK_HZ   = 20_000_000;
  localparam int unsigned INIT_US      = 625;
  localparam int unsigned INIT_CYC     = INIT_US * (SYS_CLK_HZ / 1_000_000);
  localparam int unsigned LOCK_LOW_S   = 10;
  localparam int unsigned LOCK_LOW_CYC = LOCK_LOW_S * SYS_CLK_HZ;
  localparam int unsigned REALIGN_S    = 5;
  localparam int unsigned REALIGN_CYC  = REALIGN_S * SYS_CLK_HZ;
  localparam int unsigned HIST_MS      = 10;
  localparam int unsigned HIST_CYC     = HIST_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned HIST_DEPTH   = 4;
  localparam int unsigned TMR_W        = 28;
  // nco: 11 integer bits of 16.384 MHz cycles (one frame) plus fraction
  localparam int unsigned FRAC_BITS    = 24;
  localparam int unsigned ACC_W        = FRAC_BITS + 11;
  localparam int unsigned PH_W         = 19;
  localparam int unsigned STEER_W      = 16;
  localparam logic [23:0] NOM_INC16    = 24'hd1b717;
  localparam logic [23:0] NOM_INC19    = 24'hf8d4fe;
  localparam int unsigned LIMIT_NS     = 41;
  localparam int unsigned LIMIT_WIN_US = 1326;
  localparam int unsigned LIM_STEER    = 13743895 * LIMIT_NS / (LIMIT_WIN_US * 1000);
  localparam int unsigned FILT_SHIFT   = 10;
  localparam int unsigned LOCK_NS      = 20;
  localparam int unsigned LOCK_ERR     = LOCK_NS * 16384 * 256 / 1_000_000;
  localparam logic [4:0]  LOCK_QUAL    = 5'h10;
  localparam logic [11:0] LOSS_CYC     = 12'hbb8;
  localparam logic [11:0] P8K_MIN      = 12'h960;
  localparam logic [11:0] P8K_MAX      = 12'ha28;
  localparam logic [11:0] P1M5_MIN     = 12'h00c;
  localparam logic [11:0] P1M5_MAX     = 12'h00e;
  localparam logic [11:0] P2M_MIN      = 12'h009;
  localparam logic [11:0] P2M_MAX      = 12'h00b;
  localparam logic [11:0] P19M_MIN     = 12'h01e;
  localparam logic [11:0] P19M_MAX     = 12'h028;
  localparam logic [11:0] DIV_8K       = 12'h001;
  localparam logic [11:0] DIV_1M5      = 12'h0c1;
  localparam logic [11:0] DIV_2M       = 12'h100;
  localparam logic [11:0] DIV_19M      = 12'h046;
  localparam logic [1:0]  MODE_NORMAL  = 2'h0;
  localparam logic [1:0]  MODE_HOLD    = 2'h1;
  localparam logic [1:0]  MODE_FREE    = 2'h2;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_PHASE   = 8'h08;
  localparam logic [7:0]  ADDR_FREQ    = 8'h0c;
  localparam int unsigned CTRL_OUT_EN  = 0;
  localparam logic        CTRL_RESET   = 1'b1;
  typedef enum logic [2:0] {
    ST_INIT   = 3'b000,
    ST_FREE   = 3'b001,
    ST_NORMAL = 3'b010,
    ST_HOLD   = 3'b011,
    ST_AUTO   = 3'b100
  } dpll_state_t;
  typedef enum logic [2:0] {
    REF_NONE = 3'b000,
    REF_8K   = 3'b001,
    REF_1M5  = 3'b010,
    REF_2M   = 3'b011,
    REF_19M  = 3'b100
  } ref_class_t;
endpackage

// file: rtl/network_timing_dpll.sv
`timescale 1ns/100ps
module network_timing_dpll
  import dpll_pkg::*;
#(
  parameter int unsigned ADDR_W      = 8,
  parameter int unsigned INIT_CYCLES = INIT_CYC,
  parameter int unsigned HIST_CYCLES = HIST_CYC,
  parameter int unsigned LOW_CYCLES  = LOCK_LOW_CYC,
  parameter int unsigned RLGN_CYCLES = REALIGN_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              primary_ref_in,
  input  wire logic              secondary_ref_in,
  input  wire logic              ref_source_sel,
  input  wire logic              mode_sel_hi,
  input  wire logic              mode_sel_lo,
  input  wire logic              phase_realign_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   clk_2m_out,
  output logic                   clk_8m_out,
  output logic                   clk_16m_out,
  output logic                   frame_pulse_n,
  output logic                   apll_feed_out,
  output logic                   lock_out,
  output logic                   holdover_out
);
  localparam int unsigned PIN_PRI = 0;
  localparam int unsigned PIN_SEC = 1;
  localparam int unsigned PIN_SEL = 2;
  localparam int unsigned PIN_LO  = 3;
  localparam int unsigned PIN_HI  = 4;
  localparam int unsigned PIN_RLG = 5;
  localparam logic [5:0]  PIN_RST = 6'h23; // idle levels, no false edge after reset
  localparam logic signed [PH_W-1:0] LIM_PH  = PH_W'(LIM_STEER);
  localparam logic signed [PH_W-1:0] LOCK_PH = PH_W'(LOCK_ERR);

  // pin synchronisers: only the second stage is read
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_s1_reg <= PIN_RST;
      pin_s2_reg <= PIN_RST;
    end else begin
      pin_s1_reg <= {phase_realign_n, mode_sel_hi, mode_sel_lo,
                     ref_source_sel, secondary_ref_in, primary_ref_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire       ref_s  = pin_s2_reg[PIN_SEL] ? pin_s2_reg[PIN_SEC] : pin_s2_reg[PIN_PRI]; // R3
  wire [1:0] mode_s = {pin_s2_reg[PIN_HI], pin_s2_reg[PIN_LO]}; // R7
  wire       rl_s   = pin_s2_reg[PIN_RLG];

  // reference rate detection
  logic       ref_prev_reg;
  logic [11:0] per_cnt_reg;
  ref_class_t class_reg;
  ref_class_t per_class;

  wire ref_rise = ref_s & ~ref_prev_reg;
  wire ref_fall = ~ref_s & ref_prev_reg;
  wire in_8k    = (per_cnt_reg >= P8K_MIN) && (per_cnt_reg <= P8K_MAX);
  wire in_1m5   = (per_cnt_reg >= P1M5_MIN) && (per_cnt_reg <= P1M5_MAX);
  wire in_2m    = (per_cnt_reg >= P2M_MIN) && (per_cnt_reg <= P2M_MAX);
  wire in_19m   = (per_cnt_reg >= P19M_MIN) && (per_cnt_reg <= P19M_MAX);
  // 19.44 MHz is seen aliased at 20 MHz sampling, as a ~0.56 MHz beat
  assign per_class = in_8k  ? REF_8K  :
                     in_1m5 ? REF_1M5 :
                     in_2m  ? REF_2M  :
                     in_19m ? REF_19M : REF_NONE; // R1
  wire ref_lost  = (per_cnt_reg == LOSS_CYC);
  wire ref_valid = (class_reg != REF_NONE);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ref_prev_reg <= 1'b1;
      per_cnt_reg  <= '0;
      class_reg    <= REF_NONE;
    end else begin
      ref_prev_reg <= ref_s;
      if (ref_rise) begin
        per_cnt_reg <= 12'h001;
        class_reg   <= per_class; // R1
      end else if (ref_lost) begin
        class_reg <= REF_NONE; // R10
      end else begin
        per_cnt_reg <= per_cnt_reg + 12'h001;
      end
    end
  end

  // virtual 8 kHz reference from the active edge
  wire act_edge = (class_reg == REF_19M) ? ref_rise : ref_fall; // R2
  wire [11:0] div_lim = (class_reg == REF_1M5) ? DIV_1M5 :
                        (class_reg == REF_2M)  ? DIV_2M  :
                        (class_reg == REF_19M) ? DIV_19M : DIV_8K;
  logic [11:0] div_cnt_reg;
  logic        vref_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_cnt_reg <= '0;
      vref_reg    <= 1'b0;
    end else begin
      vref_reg <= 1'b0;
      if (act_edge && ref_valid) begin
        if (div_cnt_reg >= div_lim - 12'h001) begin
          div_cnt_reg <= '0;
          vref_reg    <= 1'b1; // R14
        end else begin
          div_cnt_reg <= div_cnt_reg + 12'h001;
        end
      end
    end
  end

  // operating mode state machine
  dpll_state_t state_reg;
  dpll_state_t state_next;
  logic [TMR_W-1:0] init_cnt_reg;
  wire init_done = (init_cnt_reg == TMR_W'(INIT_CYCLES - 1));
  wire is_hold   = (state_reg == ST_HOLD) || (state_reg == ST_AUTO);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_INIT: begin
        if (init_done) state_next = ST_FREE; // R22
      end
      ST_FREE, ST_NORMAL, ST_HOLD, ST_AUTO: begin
        case (mode_s)
          MODE_NORMAL: state_next = ref_valid ? ST_NORMAL : ST_AUTO; // R10
          MODE_HOLD:   state_next = ST_HOLD; // R10
          MODE_FREE:   state_next = ST_FREE;
          default:     state_next = state_reg; // R23
        endcase
      end
      default: state_next = ST_INIT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg    <= ST_INIT;
      init_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_INIT && !init_done) begin
        init_cnt_reg <= init_cnt_reg + TMR_W'(1); // R22
      end
    end
  end

  wire enter_normal = (state_next == ST_NORMAL) && (state_reg != ST_NORMAL);
  wire leave_normal = (state_next != ST_NORMAL) && (state_reg == ST_NORMAL);

  // nco phase accumulators
  logic [ACC_W-1:0]     acc16_reg;
  logic [FRAC_BITS-1:0] acc19_reg;
  logic [23:0]          inc16_reg;
  logic [23:0]          inc19_reg;
  logic [23:0]          hold_inc_reg;
  logic signed [FRAC_BITS+FILT_SHIFT-1:0] filt_reg;
  logic signed [PH_W-1:0] tie_off_reg;
  logic                   tie_cap_reg;

  wire [ACC_W-1:0] acc16_next = acc16_reg + {11'h000, inc16_reg};
  wire signed [STEER_W-1:0] steer = filt_reg[FILT_SHIFT+STEER_W-1:FILT_SHIFT];
  wire [23:0] steer_ext = {{(24-STEER_W){steer[STEER_W-1]}}, steer};
  wire [23:0] inc16_next = (state_reg == ST_NORMAL) ? NOM_INC16 + steer_ext : // R9
                           is_hold ? hold_inc_reg : NOM_INC16; // R8 R11
  wire [23:0] inc19_next = (state_reg == ST_NORMAL) ? NOM_INC19 + steer_ext :
                           is_hold ? NOM_INC19 + (hold_inc_reg - NOM_INC16) : NOM_INC19;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      acc16_reg <= '0;
      acc19_reg <= '0;
      inc16_reg <= NOM_INC16;
      inc19_reg <= NOM_INC19;
    end else begin
      acc16_reg <= acc16_next;
      acc19_reg <= acc19_reg + inc19_reg;
      inc16_reg <= inc16_next;
      inc19_reg <= inc19_next;
    end
  end

  // phase detector, tie corrector, limiter, loop filter
  wire [PH_W-1:0] phase_smp = acc16_reg[ACC_W-1:FRAC_BITS-8];
  wire signed [PH_W-1:0] ph_err = $signed(phase_smp) - tie_off_reg; // R14
  wire signed [PH_W-1:0] neg_err = -ph_err;
  wire signed [PH_W-1:0] lim_ph = (neg_err > LIM_PH) ? LIM_PH :
                                  (neg_err < -LIM_PH) ? -LIM_PH : neg_err; // R12
  wire signed [FRAC_BITS+FILT_SHIFT-1:0] lim_ext =
    {{(FRAC_BITS+FILT_SHIFT-PH_W){lim_ph[PH_W-1]}}, lim_ph};
  // fixed 2^-10 step at 8 kHz gives a corner near 1.2 Hz for every rate
  wire signed [FRAC_BITS+FILT_SHIFT-1:0] filt_delta =
    ((lim_ext <<< FILT_SHIFT) - filt_reg) >>> FILT_SHIFT; // R13
  wire err_in   = (ph_err <= LOCK_PH) && (ph_err >= -LOCK_PH);
  wire loop_upd = vref_reg && (state_reg == ST_NORMAL) && !tie_cap_reg;

  logic rl_prev_reg;
  logic rl_busy_reg;
  logic rl_fire_reg;
  logic lock_reg;
  wire rl_fall  = rl_prev_reg & ~rl_s;
  wire rl_start = rl_fall & lock_reg; // R5

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tie_off_reg <= '0;
      tie_cap_reg <= 1'b0;
      filt_reg    <= '0;
    end else begin
      if (rl_start) begin
        tie_off_reg <= '0; // R5
        tie_cap_reg <= 1'b0;
      end else if (enter_normal) begin
        tie_cap_reg <= 1'b1;
      end else if (vref_reg && tie_cap_reg) begin
        // keep today's phase: no output hit when lock is first taken
        tie_off_reg <= $signed(phase_smp);
        tie_cap_reg <= 1'b0;
      end
      if (loop_upd) begin
        filt_reg <= filt_reg + filt_delta; // R13
      end
    end
  end

  // frequency history for holdover
  logic [TMR_W-1:0] hist_cnt_reg;
  logic [2:0]       hist_fill_reg;
  logic [23:0]      hist_old;
  wire hist_tick = (state_reg == ST_NORMAL) && (hist_cnt_reg == TMR_W'(HIST_CYCLES - 1));
  wire hist_full = (hist_fill_reg == 3'(HIST_DEPTH));

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hist_cnt_reg  <= '0;
      hist_fill_reg <= '0;
      hold_inc_reg  <= NOM_INC16;
    end else begin
      if (state_reg != ST_NORMAL || hist_tick) begin
        hist_cnt_reg <= '0;
      end else begin
        hist_cnt_reg <= hist_cnt_reg + TMR_W'(1);
      end
      if (hist_tick && !hist_full) begin
        hist_fill_reg <= hist_fill_reg + 3'h1;
      end
      if (leave_normal) begin
        // no history after reset: holdover runs at free-run accuracy
        hold_inc_reg <= hist_full ? hist_old : NOM_INC16; // R11
      end
    end
  end

  dpll_hist_mem #(
    .W     (24),
    .DEPTH (HIST_DEPTH)
  ) u_hist (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .wr_en    (hist_tick),
    .wr_data  (inc16_reg),
    .old_data (hist_old)
  );

  // lock indication and realignment
  logic [4:0]       qual_cnt_reg;
  logic [TMR_W-1:0] low_cnt_reg;
  logic [TMR_W-1:0] rl_cnt_reg;
  wire qual_full = (qual_cnt_reg == LOCK_QUAL);
  wire low_done  = (low_cnt_reg >= TMR_W'(LOW_CYCLES - 1));
  wire rl_done   = (rl_cnt_reg == TMR_W'(RLGN_CYCLES - 1));
  wire lock_drop = (state_reg != ST_NORMAL) || rl_fire_reg ||
                   (loop_upd && !err_in && !rl_busy_reg); // R18 R6
  wire lock_next = lock_drop ? 1'b0 : (lock_reg || (qual_full && low_done)); // R19

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      qual_cnt_reg <= '0;
      low_cnt_reg  <= '0;
      lock_reg     <= 1'b0;
    end else begin
      lock_reg <= lock_next;
      if (state_reg != ST_NORMAL || rl_start) begin
        qual_cnt_reg <= '0;
      end else if (loop_upd) begin
        qual_cnt_reg <= !err_in ? 5'h00 : qual_full ? qual_cnt_reg : qual_cnt_reg + 5'h01; // R18
      end
      if (lock_reg) begin
        low_cnt_reg <= '0;
      end else if (!low_done) begin
        low_cnt_reg <= low_cnt_reg + TMR_W'(1); // R19
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rl_prev_reg <= 1'b1;
      rl_busy_reg <= 1'b0;
      rl_cnt_reg  <= '0;
      rl_fire_reg <= 1'b0;
    end else begin
      rl_prev_reg <= rl_s;
      rl_fire_reg <= rl_busy_reg && rl_done; // R6
      if (rl_start) begin
        rl_busy_reg <= 1'b1;
        rl_cnt_reg  <= '0;
      end else if (rl_busy_reg) begin
        rl_busy_reg <= !rl_done;
        rl_cnt_reg  <= rl_cnt_reg + TMR_W'(1);
      end
    end
  end

  // apb slave, one wait-free access phase
  logic        out_en_reg;
  logic [PH_W-1:0] ph_last_reg;
  wire setup   = psel && !penable;
  wire wr_take = psel && penable && pready && pwrite;
  wire hit_ctrl = (paddr == ADDR_W'(ADDR_CTRL));
  wire hit_stat = (paddr == ADDR_W'(ADDR_STATUS));
  wire hit_ph   = (paddr == ADDR_W'(ADDR_PHASE));
  wire hit_freq = (paddr == ADDR_W'(ADDR_FREQ));
  wire unmapped = !(hit_ctrl || hit_stat || hit_ph || hit_freq);
  wire [31:0] stat_val = {22'h000000, hist_full, ref_valid, class_reg,
                          holdover_out, lock_reg, state_reg};
  wire [31:0] rd_val = hit_ctrl ? {31'h00000000, out_en_reg} :
                       hit_stat ? stat_val :
                       hit_ph   ? {{(32-PH_W){ph_last_reg[PH_W-1]}}, ph_last_reg} :
                       hit_freq ? {8'h00, inc16_reg} : 32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata     <= '0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      out_en_reg <= CTRL_RESET;
    end else begin
      pready  <= setup;
      pslverr <= setup && unmapped;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_val;
      end
      if (wr_take && hit_ctrl) begin
        out_en_reg <= pwdata[CTRL_OUT_EN];
      end
    end
  end

  // clock synthesiser outputs; at 20 MHz sampling they carry nco jitter
  wire frame_edge = (acc16_next[ACC_W-1:FRAC_BITS] == 11'h000) &&
                    (acc16_reg[ACC_W-1:FRAC_BITS] != 11'h000);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ph_last_reg   <= '0;
      clk_2m_out    <= 1'b0;
      clk_8m_out    <= 1'b0;
      clk_16m_out   <= 1'b0;
      frame_pulse_n <= 1'b1;
      apll_feed_out <= 1'b0;
      holdover_out  <= 1'b0;
    end else begin
      if (vref_reg) ph_last_reg <= ph_err;
      clk_16m_out   <= out_en_reg & acc16_reg[FRAC_BITS-1]; // R15
      clk_8m_out    <= out_en_reg & acc16_reg[FRAC_BITS]; // R15
      clk_2m_out    <= out_en_reg & acc16_reg[FRAC_BITS+2]; // R15
      frame_pulse_n <= !(out_en_reg && frame_edge); // R16
      apll_feed_out <= acc19_reg[FRAC_BITS-1]; // R17
      holdover_out  <= is_hold; // R20
    end
  end

  assign lock_out = lock_reg;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic [TMR_W-1:0] chk_low_reg;
  always_ff @(posedge sys_clk) begin
    if (!resetn || lock_reg) chk_low_reg <= '0;
    else if (chk_low_reg != {TMR_W{1'b1}}) chk_low_reg <= chk_low_reg + TMR_W'(1);
  end

  sequence s_rl_start;
    lock_reg && rl_prev_reg && !rl_s;
  endsequence
  sequence s_rl_fire;
    rl_busy_reg && rl_done;
  endsequence

  AST_REALIGN_ARM: assert property (s_rl_start |=> rl_busy_reg && tie_off_reg == 0) // R5
    else $error("realign did not arm or clear offset");
  AST_REALIGN_DROP: assert property (s_rl_fire |=> ##1 !lock_reg) // R6
    else $error("lock not dropped after realign delay");
  AST_LOCK_LOW: assert property ($rose(lock_reg) |-> $past(chk_low_reg) >= TMR_W'(LOW_CYCLES - 1)) // R19
    else $error("lock rose before minimum low time");
  AST_LOCK_QUAL: assert property ($rose(lock_reg) |-> $past(qual_full) && state_reg == ST_NORMAL) // R18
    else $error("lock rose without phase qualification");
  AST_RESERVED_KEEP: assert property (mode_s == 2'h3 && state_reg != ST_INIT |=> $stable(state_reg)) // R23
    else $error("reserved mode changed state");
  AST_HOLDOVER_OUT: assert property (is_hold |=> holdover_out) // R20
    else $error("holdover output low in holdover");
  AST_FREERUN_NOM: assert property (state_reg == ST_FREE |=> inc16_reg == NOM_INC16) // R8
    else $error("free-run increment not nominal");
  AST_HOLD_STABLE: assert property (state_reg == ST_HOLD ##1 state_reg == ST_HOLD |=> $stable(inc16_reg)) // R11
    else $error("holdover frequency moved");
  AST_FRAME_WIDTH: assert property ($fell(frame_pulse_n) |=> frame_pulse_n [*8]) // R16
    else $error("frame pulse too wide or too close");
  AST_LIMIT: assert property (lim_ph <= LIM_PH && lim_ph >= -LIM_PH) // R12
    else $error("limited error out of range");
  AST_INIT_EXIT: assert property (state_reg == ST_INIT ##1 state_reg != ST_INIT |-> state_reg == ST_FREE && $past(init_cnt_reg) == TMR_W'(INIT_CYCLES - 1)) // R22
    else $error("initialisation length wrong");
  AST_LOSS_AUTO: assert property (state_reg == ST_NORMAL && !ref_valid && mode_s == MODE_NORMAL |=> state_reg == ST_AUTO) // R10
    else $error("lost reference did not enter holdover");
endmodule

// file: testbench/network_timing_dpll_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module network_timing_dpll_tb_top;
  import dpll_pkg::*;
  logic        sys_clk, resetn, ref_en, secondary_ref_in, ref_source_sel;
  logic        mode_sel_hi, mode_sel_lo, phase_realign_n, psel, penable, pwrite;
  logic        pready, pslverr, clk_2m_out, clk_8m_out, clk_16m_out, frame_pulse_n;
  logic        apll_feed_out, lock_out, holdover_out, primary_ref_in, slv, p2, p8;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, checks, n, r2, r8, h16, h19;
  logic [1:0]  pins [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [2:0]  st_exp [4] = '{3'h3, 3'h3, 3'h1, 3'h4};
  logic        ho_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  ref_clk_src i_ref_clk_src (.en(ref_en), .ref_out(primary_ref_in));

  network_timing_dpll #(.INIT_CYCLES(20), .HIST_CYCLES(50), .LOW_CYCLES(100),
    .RLGN_CYCLES(50)) i_network_timing_dpll (.sys_clk, .resetn, .primary_ref_in,
    .secondary_ref_in, .ref_source_sel, .mode_sel_hi, .mode_sel_lo, .phase_realign_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clk_2m_out,
    .clk_8m_out, .clk_16m_out, .frame_pulse_n, .apll_feed_out, .lock_out, .holdover_out);

  always #25 sys_clk = ~sys_clk;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      fail_count++;
      complete_run();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic stat(input logic [2:0] st, input logic ho);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("state", st, rd[2:0])
    `CHK("holdover_out", ho, holdover_out)
  endtask

  initial begin
    {sys_clk, resetn, ref_en, ref_source_sel, psel, penable, pwrite, mode_sel_lo} = '0;
    {secondary_ref_in, phase_realign_n, mode_sel_hi} = 3'h7;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_count = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    stat(3'h0, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, slv)
    `CHK("unmapped data", 32'h0, rd)
    $display("test reset_and_map done");
    repeat (25) @(posedge sys_clk);
    stat(3'h1, 1'b0);
    apb(1'b0, ADDR_FREQ, 32'h0);
    `CHK("freq", 32'(NOM_INC16), rd)
    n = 0;
    r2 = 0;
    r8 = 0;
    h16 = 0;
    h19 = 0;
    p2 = clk_2m_out;
    p8 = clk_8m_out;
    // three frames at 2500 cycles each, one low cycle per frame
    repeat (7500) begin
      @(posedge sys_clk);
      n += (frame_pulse_n === 1'b0);
      r2 += (clk_2m_out === 1'b1 && p2 === 1'b0);
      r8 += (clk_8m_out === 1'b1 && p8 === 1'b0);
      h16 += (clk_16m_out === 1'b1);
      h19 += (apll_feed_out === 1'b1);
      p2 = clk_2m_out;
      p8 = clk_8m_out;
    end
    `CHK("frame lows", 3, n)
    // 375 us of output: 768 and 3072 periods, about half the samples high
    `CHK("clk_2m rises", 768, r2)
    `CHK("clk_8m rises", 3072, r8)
    `CHK("clk_16m duty", 1'b1, h16 > 3700 && h16 < 3800)
    `CHK("apll_feed duty", 1'b1, h19 > 3700 && h19 < 3800)
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl off", 32'h0, rd)
    n = 0;
    repeat (2600) begin
      @(posedge sys_clk);
      n += (clk_16m_out !== 1'b0 || frame_pulse_n !== 1'b1);
    end
    `CHK("gated outputs", 0, n)
    apb(1'b1, ADDR_CTRL, 32'h1);
    $display("test free_run done");
    foreach (pins[i]) begin
      {mode_sel_hi, mode_sel_lo} <= pins[i];
      repeat (5) @(posedge sys_clk);
      stat(st_exp[i], ho_exp[i]);
    end
    $display("test modes done");
    ref_en <= 1'b1;
    repeat (100) @(posedge sys_clk);
    stat(3'h2, 1'b0);
    `CHK("ref class", 3'h3, rd[7:5])
    for (n = 0; n < 60000 && lock_out !== 1'b1; n++)
      @(posedge sys_clk);
    `CHK("lock", 1'b1, lock_out)
    $display("test lock done");
    phase_realign_n <= 1'b0;
    repeat (40) @(posedge sys_clk);
    `CHK("lock before delay", 1'b1, lock_out)
    repeat (30) @(posedge sys_clk);
    `CHK("lock after delay", 1'b0, lock_out)
    n = 0;
    repeat (100) begin
      @(posedge sys_clk);
      n += (lock_out !== 1'b0);
    end
    `CHK("lock low time", 0, n)
    repeat (4830) @(posedge sys_clk);
    phase_realign_n <= 1'b1;
    $display("test realign done");
    ref_source_sel <= 1'b1;
    repeat (3200) @(posedge sys_clk);
    stat(3'h4, 1'b1);
    ref_source_sel <= 1'b0;
    repeat (200) @(posedge sys_clk);
    stat(3'h2, 1'b0);
    $display("test ref_select done");
    complete_run();
  end
endmodule

// file: testbench/ref_clk_src.sv
`timescale 1ns/100ps
module ref_clk_src #(
  parameter realtime HALF_NS = 244.140625
) (
  input  wire logic en,
  output logic      ref_out
);
  realtime t_edge;
  // edges placed on an absolute grid: 100 ps rounding never builds up
  // into a frequency error the loop could not pull in
  // a disabled source leaves the pin at its pull-up level, no edges
  initial begin
    ref_out = 1'b1;
    t_edge = 0.0;
    forever begin
      t_edge += HALF_NS;
      #(t_edge - $realtime);
      ref_out = en ? ~ref_out : 1'b1;
    end
  end
endmodule
